// ---- common/exec_slice_pkg.sv ----
// Purpose: constants for the partial instruction execution slice
// Assumes: 12-bit instruction words, 8-bit data, 11-bit program counter
// Notes: opcode patterns are compared after masking the operand fields
package exec_slice_pkg;
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int FADDR_W = 5;
  localparam int JUMP_K_W = 9;
  localparam int PAGE_W = 2;
  localparam int PAGE_LO = 5;
  localparam int PAGE_HI = 6;
  localparam int DEST_BIT = 5;
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);
  localparam logic [INSTR_W-1:0] MASK_BYTE_OP = 12'hFC0;
  localparam logic [INSTR_W-1:0] MASK_JUMP = 12'hE00;
  localparam logic [INSTR_W-1:0] MASK_LIT = 12'hF00;
  localparam logic [INSTR_W-1:0] PAT_DEC = 12'h0C0;
  localparam logic [INSTR_W-1:0] PAT_DEC_SKIP = 12'h2C0;
  localparam logic [INSTR_W-1:0] PAT_OR_REG = 12'h100;
  localparam logic [INSTR_W-1:0] PAT_COPY = 12'h200;
  localparam logic [INSTR_W-1:0] PAT_JUMP = 12'hA00;
  localparam logic [INSTR_W-1:0] PAT_OR_LIT = 12'hD00;
  localparam logic [INSTR_W-1:0] PAT_LOAD_LIT = 12'hC00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  typedef enum logic [1:0] {EX_RUN, EX_FLUSH} exec_state_e;
endpackage

// ---- rtl/exec_slice.sv ----
// Purpose: executes one slice of the 12-bit instruction set
// Assumes: register file read is combinational via REG_ADDR/REG_RDATA
// Notes: other opcodes retire as one-cycle no-operations here
// Function
// - decrement register, result to working reg or register, zero flag updated.
// - decrement and skip if zero, no flags; zero result flushes next, two cycles.
// - jump loads 9-bit immediate into pc<8:0>, status<6:5> into pc<10:9>.
// - every unconditional jump takes two instruction cycles.
// - or working register with 8-bit literal into working reg, zero flag updated.
// - or working register with register, to selected destination, zero flag updated.
// - copy register to selected destination, zero flag updated in both cases.
// - instruction cycle is four clocks; skips and pc changes take two cycles.
`timescale 1ns/10ps
module exec_slice
  import exec_slice_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [exec_slice_pkg::INSTR_W-1:0] INSTR,
  input wire logic [exec_slice_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic [exec_slice_pkg::DATA_W-1:0] STATUS_IN,
  output logic [exec_slice_pkg::FADDR_W-1:0] REG_ADDR,
  output logic REG_WE,
  output logic [exec_slice_pkg::DATA_W-1:0] REG_WDATA,
  output logic [exec_slice_pkg::DATA_W-1:0] W_OUT,
  output logic ZERO_WE,
  output logic ZERO_VAL,
  output logic PC_LOAD,
  output logic [exec_slice_pkg::PC_W-1:0] PC_TARGET,
  output logic CYCLE_END,
  output logic INSTR_TAKE,
  output logic FLUSH
);
  import exec_slice_pkg::*;

  // ==========================================================
  // phase divider
  // ==========================================================
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic cyc_end;
  // four clocks per instruction cycle; the last phase is the execute strobe
  always_comb begin
    phase_d = (phase_q == PHASE_LAST) ? 2'h0 : phase_q + 2'h1;
  end
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_d;
    end
  end
  // one-cycle enable; nothing else divides the clock
  assign cyc_end = (phase_q == PHASE_LAST);
  assign CYCLE_END = cyc_end;

  // ==========================================================
  // decode
  // ==========================================================
  function automatic logic is_op(input logic [INSTR_W-1:0] ins,
                                 input logic [INSTR_W-1:0] mask,
                                 input logic [INSTR_W-1:0] pat);
    return (ins & mask) == pat;
  endfunction

  // both decrement forms share this; wraps from zero to all ones
  function automatic logic [DATA_W-1:0] minus_one(input logic [DATA_W-1:0] v);
    return v - DATA_ONE;
  endfunction

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == DATA_ZERO;
  endfunction

  logic decrement_register_op;
  logic decrement_skip_if_null_op;
  logic unconditional_jump_op;
  logic or_literal_op;
  logic or_register_op;
  logic copy_register_op;
  logic load_literal_op;
  logic dest_reg;
  logic [DATA_W-1:0] lit;
  // patterns are disjoint, so at most one op flag is high
  assign decrement_register_op = is_op(INSTR, MASK_BYTE_OP, PAT_DEC);
  assign decrement_skip_if_null_op = is_op(INSTR, MASK_BYTE_OP, PAT_DEC_SKIP);
  assign or_register_op = is_op(INSTR, MASK_BYTE_OP, PAT_OR_REG);
  assign copy_register_op = is_op(INSTR, MASK_BYTE_OP, PAT_COPY);
  assign unconditional_jump_op = is_op(INSTR, MASK_JUMP, PAT_JUMP);
  assign or_literal_op = is_op(INSTR, MASK_LIT, PAT_OR_LIT);
  assign load_literal_op = is_op(INSTR, MASK_LIT, PAT_LOAD_LIT);

  assign dest_reg = INSTR[DEST_BIT];
  assign lit = INSTR[DATA_W-1:0];
  // register address is the low operand field for every byte op
  assign REG_ADDR = INSTR[FADDR_W-1:0];

  // ==========================================================
  // execute and flush sequencing
  // ==========================================================
  exec_state_e state_q;
  exec_state_e state_d;
  logic [DATA_W-1:0] w_q;
  logic [DATA_W-1:0] w_d;
  // result feeds every write path, so it settles once per cycle
  logic [DATA_W-1:0] result;
  logic active;
  logic wr_w;
  logic wr_f;
  logic set_z;
  logic pc_chg;

  always_comb begin
    result = DATA_ZERO;
    wr_w = 1'b0;
    wr_f = 1'b0;
    set_z = 1'b0;
    pc_chg = 1'b0;
    active = cyc_end && (state_q == EX_RUN);
    // unknown words fall through with every strobe low, retiring as a no-op
    if (decrement_register_op) begin
      result = minus_one(REG_RDATA);
      wr_w = !dest_reg;
      wr_f = dest_reg;
      set_z = 1'b1;
    end else if (decrement_skip_if_null_op) begin
      result = minus_one(REG_RDATA);
      wr_w = !dest_reg;
      wr_f = dest_reg;
      pc_chg = is_zero(result);
    end else if (or_register_op) begin
      result = w_q | REG_RDATA;
      wr_w = !dest_reg;
      wr_f = dest_reg;
      set_z = 1'b1;
    end else if (copy_register_op) begin
      result = REG_RDATA;
      wr_w = !dest_reg;
      wr_f = dest_reg;
      set_z = 1'b1;
    end else if (or_literal_op) begin
      result = w_q | lit;
      wr_w = 1'b1;
      set_z = 1'b1;
    end else if (load_literal_op) begin
      result = lit;
      wr_w = 1'b1;
    end else if (unconditional_jump_op) begin
      pc_chg = 1'b1;
    end
  end

  // ==========================================================
  // flush sequencing
  // ==========================================================
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      EX_RUN: begin
        // the already fetched word is discarded in the flush cycle
        if (active && pc_chg) begin
          state_d = EX_FLUSH;
        end
      end
      EX_FLUSH: begin
        if (cyc_end) begin
          state_d = EX_RUN;
        end
      end
      default: begin
        // a two-bit code has two unused values; recover to run
        state_d = EX_RUN;
      end
    endcase
  end
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_q <= EX_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // working register
  // ==========================================================
  always_comb begin
    w_d = w_q;
    if (active && wr_w) begin
      w_d = result;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      w_q <= W_RESET;
    end else begin
      w_q <= w_d;
    end
  end

  // ==========================================================
  // working register and register file write
  // ==========================================================
  // strobes fire on the last phase only so the file sees one write per cycle
  assign W_OUT = w_q;
  assign REG_WE = active && wr_f;
  assign REG_WDATA = result;

  // ==========================================================
  // zero flag
  // ==========================================================
  // the flag register lives outside; skip and load leave it alone
  assign ZERO_WE = active && set_z;
  assign ZERO_VAL = is_zero(result);

  // ==========================================================
  // program counter and fetch
  // ==========================================================
  assign PC_LOAD = active && unconditional_jump_op;
  // page bits come from status so far jumps need no extra word
  assign PC_TARGET = {STATUS_IN[PAGE_HI:PAGE_LO], INSTR[JUMP_K_W-1:0]};
  // fetch drops its own word while flush stands; a skip gives no pc load
  assign INSTR_TAKE = cyc_end;
  assign FLUSH = (state_q == EX_FLUSH);
endmodule

// ---- tb/exec_slice_properties.sv ----
// Purpose: concurrent checks on the execution slice ports
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the top-level ports of the slice
`timescale 1ns/10ps
module exec_slice_properties (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic REG_WE,
  input wire logic ZERO_WE,
  input wire logic PC_LOAD,
  input wire logic CYCLE_END,
  input wire logic FLUSH,
  input wire logic [11:0] INSTR,
  input wire logic [7:0] REG_RDATA,
  input wire logic [7:0] STATUS_IN,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] W_OUT,
  input wire logic [10:0] PC_TARGET
);
  // ====================
  // properties
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  wire ex = CYCLE_END && !FLUSH;
  jump_target_a: assert property (PC_LOAD |-> PC_TARGET == {STATUS_IN[6:5], INSTR[8:0]})
    else $error("jump target wrong");
  jump_flush_a: assert property (ex && INSTR[11:9] == 3'h5 |-> PC_LOAD ##1 FLUSH [*4])
    else $error("jump not two cycles");
  dec_value_a: assert property (ex && INSTR[11:5] == 7'h06 |=> W_OUT == $past(REG_RDATA) - 8'h01)
    else $error("decrement result wrong");
  skip_flush_a: assert property (ex && INSTR[11:6] == 6'h0B |-> !ZERO_WE ##1 FLUSH == ($past(REG_RDATA) == 8'h01))
    else $error("skip flush wrong");
  flush_quiet_a: assert property (FLUSH |-> !REG_WE && !ZERO_WE && !PC_LOAD)
    else $error("strobe while flushed");
  or_lit_a: assert property (ex && INSTR[11:8] == 4'hD |-> ZERO_WE ##1 W_OUT == ($past(W_OUT) | $past(INSTR[7:0])))
    else $error("or literal wrong");
  load_lit_a: assert property (ex && INSTR[11:8] == 4'hC |-> !ZERO_WE ##1 W_OUT == $past(INSTR[7:0]))
    else $error("load literal wrong");
  copy_reg_a: assert property (ex && INSTR[11:5] == 7'h11 |-> REG_WE && ZERO_WE && REG_WDATA == REG_RDATA)
    else $error("copy wrong");
  cycle_len_a: assert property (CYCLE_END |=> !CYCLE_END [*3] ##1 CYCLE_END)
    else $error("cycle length wrong");
  or_reg_a: assert property (ex && INSTR[11:6] == 6'h04 |-> ZERO_WE && REG_WDATA == (W_OUT | REG_RDATA))
    else $error("or register wrong");
  cover property (ex && INSTR[11:6] == 6'h04 && !INSTR[5]);
  cover property (PC_LOAD);
  cover property (ex && INSTR[11:6] == 6'h0B ##1 FLUSH);
  cover property (REG_WE && ZERO_WE);
endmodule
bind exec_slice exec_slice_properties i_props (.*);

// ---- tb/exec_slice_test.sv ----
// Purpose: directed checks of the execution slice
// Assumes: fetch holds INSTR for a whole cycle
// Notes: inputs move on falling edges
`timescale 1ns/10ps
module exec_slice_test;
  // ====================
  // bench
  logic CLOCK = 1'b0, SYS_RST = 1'b1;
  logic [11:0] INSTR = 12'h000;
  logic [7:0] REG_RDATA = 8'h00, STATUS_IN = 8'h40;
  logic REG_WE, ZERO_WE, ZERO_VAL, PC_LOAD, CYCLE_END, FLUSH, INSTR_TAKE;
  logic [4:0] REG_ADDR;
  logic [7:0] REG_WDATA, W_OUT;
  logic [10:0] PC_TARGET;
  int err_total = 0, compares = 0;
  exec_slice i_dut (.*);
  always #4 CLOCK = ~CLOCK;
  task chk(input logic [11:0] s, input logic [11:0] e, input string nm);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_of_test;
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // zero value only counts when its strobe is high
  task op(input logic [11:0] i, input logic [7:0] r, input logic [4:0] s,
          input logic [11:0] v, input logic [7:0] w);
    int n;
    INSTR = i;
    REG_RDATA = r;
    for (n = 0; n < 8 && CYCLE_END !== 1'b1; n++) @(negedge CLOCK);
    chk(12'({FLUSH, REG_WE, ZERO_WE, PC_LOAD, ZERO_WE & ZERO_VAL}), 12'(s), "strobes");
    if (s[3]) chk(12'(REG_WDATA), v, "wdata");
    if (s[1]) chk(12'(PC_TARGET), v, "target");
    chk(12'(REG_ADDR), 12'(i[4:0]), "addr");
    chk(12'(INSTR_TAKE), 12'h001, "take");
    @(negedge CLOCK);
    chk(12'(W_OUT), 12'(w), "w");
  endtask
  task t_lit;
    op(12'hD00, 8'h00, 5'h05, 12'h000, 8'h00);
    op(12'hC9A, 8'h00, 5'h00, 12'h000, 8'h9A);
    op(12'hD35, 8'h00, 5'h04, 12'h000, 8'hBF);
  endtask
  task t_reg;
    op(12'h125, 8'h40, 5'h0C, 12'h0FF, 8'hBF);
    op(12'h105, 8'h00, 5'h04, 12'h000, 8'hBF);
    op(12'h223, 8'h00, 5'h0D, 12'h000, 8'hBF);
    op(12'h203, 8'h77, 5'h04, 12'h000, 8'h77);
    op(12'h000, 8'h00, 5'h00, 12'h000, 8'h77);
  endtask
  task t_dec;
    op(12'h0C3, 8'h01, 5'h05, 12'h000, 8'h00);
    op(12'h0E3, 8'h00, 5'h0C, 12'h0FF, 8'h00);
  endtask
  task t_skip;
    op(12'h2E4, 8'h01, 5'h08, 12'h000, 8'h00);
    op(12'h0E3, 8'h09, 5'h10, 12'h000, 8'h00);
    op(12'h2C4, 8'h05, 5'h00, 12'h000, 8'h04);
  endtask
  task t_jump;
    op(12'hB55, 8'h00, 5'h02, 12'h555, 8'h04);
    op(12'h0C3, 8'h09, 5'h10, 12'h000, 8'h04);
  endtask
  initial begin
    repeat (16) @(negedge CLOCK);
    SYS_RST = 1'b0;
    t_lit;
    t_reg;
    t_dec;
    t_skip;
    t_jump;
    end_of_test;
  end
  initial begin
    #4000;
    err_total++;
    end_of_test;
  end
endmodule
